// file: bus_ctl_model.sv
// remote controller model issuing decoded commands
`timescale 1ns/10ps
module bus_ctl_model (
    input  wire       i_clk,
    input  wire [3:0] i_op,
    input  wire       i_go,
    output reg  [9:0] o_cmd
);
    initial o_cmd = 10'h0;
    // one command line pulsed per request; op 7 is the device clear halt
    always @(posedge i_clk) begin
        o_cmd <= i_go ? 10'h1 << i_op : 10'h0;
    end
endmodule

// file: meter_err_map.vh
// constants for the error queue and trigger controller
`ifndef METER_ERR_MAP_VH
`define METER_ERR_MAP_VH
`define QUEUE_DEPTH      5'h14
`define QUEUE_LAST       5'h13
`define CODE_W           11
`define CODE_NONE        11'h000
`define CODE_TRIG_IGN    11'h72d
`define CODE_TRIG_DEAD   11'h72b
`define CODE_INIT_IGN    11'h72a
`define CODE_DATA_STALE  11'h71a
`define CODE_TOO_MANY    11'h6a2
`define CODE_QUERY_INT   11'h666
`define CODE_QUERY_UNT   11'h65c
`define CODE_QUERY_DEAD  11'h652
`define CODE_NUM_OVF     11'h785
`define CODE_DIGITS      11'h784
`define CODE_NO_MEM      11'h213
`define CODE_OVL_REF     11'h21c
`define CODE_LOCAL       11'h226
`define EXP_LIMIT        16'h7d00
`define DIGIT_LIMIT      9'h0ff
`define MEM_LIMIT        20'h00200
`define SRC_IMM          2'h0
`define SRC_BUS          2'h1
`define SRC_EXT          2'h2
`define ST_IDLE          2'h0
`define ST_WAIT          2'h1
`define ST_MEAS          2'h2
`define ADDR_CTRL        4'h0
`define ADDR_ERROR       4'h1
`define ADDR_STATUS      4'h2
`define ADDR_COUNTS      4'h3
`endif

// file: meter_err_monitor.sv
// port checks for the error queue and trigger controller
`timescale 1ns/10ps
`include "meter_err_map.vh"
module qmon (
    input wire        i_clk,
    input wire        i_rst_n,
    input wire        i_cmd_init,
    input wire        i_cmd_meas,
    input wire        i_cmd_trg,
    input wire        i_cmd_cls,
    input wire        i_dev_clear,
    input wire        i_rd,
    input wire [3:0]  i_addr,
    input wire [31:0] o_rdata,
    input wire        o_err_ind,
    input wire        o_beep,
    input wire        o_meas_start,
    input wire [1:0]  o_trig_state
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    // a read strobe aimed at the error queue
    wire pop = i_rd && i_addr == `ADDR_ERROR;
    a_empty_reads_zero: assert property (pop && !o_err_ind |=> o_rdata == 32'h0)
        else $error("empty queue read not zero");
    a_held_reads_code: assert property (pop && o_err_ind |=> o_rdata != 32'h0)
        else $error("held entry read as zero");
    a_cls_empties: assert property (i_cmd_cls |=> !o_err_ind)
        else $error("queue not empty after clear");
    a_beep_marks_ind: assert property (o_beep && !$past(i_cmd_cls) |-> o_err_ind)
        else $error("beep without indicator");
    a_start_from_wait: assert property (o_meas_start |-> $past(o_trig_state) == `ST_WAIT)
        else $error("trigger taken outside waiting");
    a_meas_arms: assert property (i_cmd_meas && o_trig_state == `ST_IDLE && !i_dev_clear
        |=> o_trig_state == `ST_WAIT)
        else $error("measure did not arm");
    a_clear_idles: assert property (i_dev_clear |=> o_trig_state == `ST_IDLE)
        else $error("device clear did not idle");
    a_busy_init: assert property (i_cmd_init && o_trig_state == `ST_MEAS |=> o_beep)
        else $error("busy initiate not flagged");
    a_idle_trg: assert property (i_cmd_trg && o_trig_state == `ST_IDLE
        |=> o_beep && o_trig_state == `ST_IDLE)
        else $error("idle trigger not ignored");
    // main scenarios reached
    c_pop_held: cover property (pop && o_err_ind);
    c_start: cover property (o_meas_start);
    c_busy: cover property (i_cmd_init && o_trig_state == `ST_MEAS);
endmodule

// file: meter_error_queue_trigger_ctl.v
// error queue and trigger state controller of a bench meter
`timescale 1ns/10ps
`include "meter_err_map.vh"

module meter_error_queue_trigger_ctl (
    input  wire        i_clk,
    input  wire        i_rst_n,
    input  wire        i_cmd_init,
    input  wire        i_cmd_read,
    input  wire        i_cmd_meas,
    input  wire        i_cmd_fetch,
    input  wire        i_cmd_trg,
    input  wire        i_cmd_cls,
    input  wire        i_cmd_rst,
    input  wire        i_dev_clear,
    input  wire        i_cmd_data,
    input  wire        i_talk_addr,
    input  wire        i_out_overflow,
    input  wire        i_in_full,
    input  wire        i_out_pending,
    input  wire        i_num_valid,
    input  wire [15:0] i_num_exp,
    input  wire [8:0]  i_num_digits,
    input  wire        i_num_digits_ovf,
    input  wire        i_mem_empty,
    input  wire        i_ref_store,
    input  wire        i_ref_overload,
    input  wire        i_local,
    input  wire        i_meas_done,
    input  wire        i_ext_trig,
    input  wire [3:0]  i_addr,
    input  wire [31:0] i_wdata,
    input  wire        i_wr,
    input  wire        i_rd,
    output reg  [31:0] o_rdata,
    output reg         o_err_ind,
    output reg         o_beep,
    output reg         o_meas_start,
    output reg         o_math_on,
    output reg  [1:0]  o_trig_state
);

    // error codes queued in order of arrival
    reg [`CODE_W-1:0] queue [0:19];
    reg [4:0]         wr_ptr;
    reg [4:0]         rd_ptr;
    reg [4:0]         count;
    reg               dropping;
    reg [1:0]         trig_src;
    reg [9:0]         sample_cnt;
    reg [9:0]         trig_cnt;
    reg               ext_meta;
    reg               ext_sync;
    reg               ext_prev;

    // trigger states
    localparam [1:0] S_IDLE = `ST_IDLE;
    localparam [1:0] S_WAIT = `ST_WAIT;
    localparam [1:0] S_MEAS = `ST_MEAS;

    // sign extension of a stored code to the bus width
    function [31:0] code_word;
        input [`CODE_W-1:0] v;
        begin
            code_word = {{(32-`CODE_W){v[`CODE_W-1]}}, v};
        end
    endfunction

    // pointer step with wrap at the queue length
    function [4:0] ptr_inc;
        input [4:0] p;
        begin
            ptr_inc = (p == `QUEUE_LAST) ? 5'h00 : p + 5'h01;
        end
    endfunction

    wire ext_edge     = ext_sync & ~ext_prev;
    wire wait_st      = (o_trig_state == `ST_WAIT);
    wire arm_cmd      = i_cmd_init | i_cmd_read | i_cmd_meas;
    wire [19:0] prod  = sample_cnt * trig_cnt;

    // trigger candidates, one per selectable source
    wire hit_imm = 1'b1;
    wire hit_bus = i_cmd_trg;
    wire hit_ext = ext_edge;

    // trigger present for the selected source; unknown codes never trigger
    reg trig_hit;
    always @* begin
        case (trig_src)
            `SRC_IMM: trig_hit = hit_imm;
            `SRC_BUS: trig_hit = hit_bus;
            `SRC_EXT: trig_hit = hit_ext;
            default:  trig_hit = 1'b0;
        endcase
    end

    // individual error conditions, one per queued code
    wire bad_exp    = i_num_valid && (i_num_exp > `EXP_LIMIT);
    wire bad_digits = i_num_valid && (i_num_digits_ovf || (i_num_digits > `DIGIT_LIMIT));
    wire local_read = i_cmd_read && i_local;
    wire dead_read  = i_cmd_read && (trig_src == `SRC_BUS);
    wire busy_init  = i_cmd_init && (o_trig_state != `ST_IDLE);
    wire mem_over   = i_cmd_init && (prod > `MEM_LIMIT);
    wire lost_trig  = i_cmd_trg && !(wait_st && (trig_src == `SRC_BUS));
    wire stale      = i_cmd_fetch && i_mem_empty;
    wire ovl_ref    = i_ref_store && i_ref_overload;
    wire out_dead   = i_out_overflow && i_in_full;
    wire interrupt  = i_cmd_data && i_out_pending;
    wire unterm     = i_talk_addr && !i_out_pending;

    // select one error per cycle, most specific first
    // when several coincide only the highest-priority code is kept
    reg               err_any;
    reg [`CODE_W-1:0] err_code;
    always @* begin
        err_any  = 1'b1;
        err_code = `CODE_NONE;
        if (bad_exp)
            err_code = `CODE_NUM_OVF;
        else if (bad_digits)
            err_code = `CODE_DIGITS;
        else if (local_read)
            err_code = `CODE_LOCAL;
        else if (dead_read)
            err_code = `CODE_TRIG_DEAD;
        else if (busy_init)
            err_code = `CODE_INIT_IGN;
        else if (mem_over)
            err_code = `CODE_NO_MEM;
        else if (lost_trig)
            err_code = `CODE_TRIG_IGN;
        else if (stale)
            err_code = `CODE_DATA_STALE;
        else if (ovl_ref)
            err_code = `CODE_OVL_REF;
        else if (out_dead)
            err_code = `CODE_QUERY_DEAD;
        else if (interrupt)
            err_code = `CODE_QUERY_INT;
        else if (unterm)
            err_code = `CODE_QUERY_UNT;
        else
            err_any = 1'b0;
    end

    wire pop  = i_rd && (i_addr == `ADDR_ERROR) && (count != 5'h00);
    wire full = (count == `QUEUE_DEPTH);
    wire [4:0] newest = (wr_ptr == 5'h00) ? `QUEUE_LAST : wr_ptr - 5'h01;

    // external trigger synchroniser
    // two flops before any logic reads the pin; the third finds the edge
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            ext_meta <= 1'b0;
            ext_sync <= 1'b0;
            ext_prev <= 1'b0;
        end else begin
            ext_meta <= i_ext_trig;
            ext_sync <= ext_meta;
            ext_prev <= ext_sync;
        end
    end

    // queue storage; the reset command never touches it
    // a full queue sees its newest slot taken by the overflow marker
    always @(posedge i_clk) begin
        if (err_any && !dropping) begin
            if (full && !pop)
                queue[newest] <= `CODE_TOO_MANY;
            else
                queue[wr_ptr] <= err_code;
        end
    end

    // next queue bookkeeping; a pop frees room for an error in the same cycle unless the overflow marker is already queued
    reg [4:0] next_wr_ptr;
    reg [4:0] next_rd_ptr;
    reg [4:0] next_count;
    reg       next_dropping;
    reg       next_err_ind;
    wire      store = err_any && !dropping && !(full && !pop);
    always @* begin
        next_wr_ptr   = wr_ptr;
        next_rd_ptr   = rd_ptr;
        next_count    = count;
        next_dropping = dropping;
        next_err_ind  = o_err_ind;
        if (pop)
            next_rd_ptr = ptr_inc(rd_ptr);
        if (store) begin
            next_wr_ptr  = ptr_inc(wr_ptr);
            next_count   = pop ? count : count + 5'h01;
            next_err_ind = 1'b1;
        end else if (pop) begin
            next_count   = count - 5'h01;
            next_err_ind = (count != 5'h01);
        end
        if (pop)
            next_dropping = 1'b0;
        else if (err_any && full)
            next_dropping = 1'b1;
    end

    // queue pointers, count and indicator; clear status wins over a new error
    always @(posedge i_clk) begin
        if (!i_rst_n || i_cmd_cls) begin
            wr_ptr    <= 5'h00;
            rd_ptr    <= 5'h00;
            count     <= 5'h00;
            dropping  <= 1'b0;
            o_err_ind <= 1'b0;
        end else begin
            wr_ptr    <= next_wr_ptr;
            rd_ptr    <= next_rd_ptr;
            count     <= next_count;
            dropping  <= next_dropping;
            o_err_ind <= next_err_ind;
        end
    end

    // beeper, one pulse per cycle that detects an error
    // dropped errors still sound, they did occur
    always @(posedge i_clk) begin
        if (!i_rst_n)
            o_beep <= 1'b0;
        else
            o_beep <= err_any;
    end

    // trigger state machine
    // device clear wins over any command in the same cycle
    // refused commands (local read, memory overrun) never arm
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_trig_state <= S_IDLE;
            o_meas_start <= 1'b0;
        end else begin
            o_meas_start <= 1'b0;
            if (i_dev_clear) begin
                o_trig_state <= S_IDLE;
            end else begin
                case (o_trig_state)
                    S_IDLE: if (arm_cmd && !mem_over && !local_read) begin
                        o_trig_state <= S_WAIT;
                    end
                    S_WAIT: if (trig_hit) begin
                        o_trig_state <= S_MEAS;
                        o_meas_start <= 1'b1;
                    end
                    S_MEAS: if (i_meas_done) begin
                        o_trig_state <= S_IDLE;
                    end
                    default: o_trig_state <= S_IDLE;
                endcase
            end
        end
    end

    // register writes and math state
    // the reset command restores trigger settings and turns math off
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            trig_src   <= `SRC_IMM;
            sample_cnt <= 10'h001;
            trig_cnt   <= 10'h001;
            o_math_on  <= 1'b0;
        end else begin
            if (i_cmd_rst) begin
                trig_src   <= `SRC_IMM;
                sample_cnt <= 10'h001;
                trig_cnt   <= 10'h001;
                o_math_on  <= 1'b0;
            end else if (i_wr && i_addr == `ADDR_CTRL) begin
                trig_src  <= i_wdata[1:0];
                o_math_on <= i_wdata[2];
            end else if (i_wr && i_addr == `ADDR_COUNTS) begin
                sample_cnt <= i_wdata[9:0];
                trig_cnt   <= i_wdata[25:16];
            end
            if (i_ref_store && i_ref_overload)
                o_math_on <= 1'b0;
        end
    end

    // read words assembled from the live state
    wire [31:0] ctrl_word   = {29'h0, o_math_on, trig_src};
    wire [31:0] err_word    = (count == 5'h00) ? 32'h00000000 :
                              code_word(queue[rd_ptr]);
    wire [31:0] status_word = {24'h0, dropping, o_trig_state, count};
    wire [31:0] counts_word = {6'h0, trig_cnt, 6'h0, sample_cnt};

    // read data one cycle after the strobe
    // unmapped addresses and idle cycles read zero
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_rdata <= 32'h00000000;
        end else if (i_rd) begin
            case (i_addr)
                `ADDR_CTRL:   o_rdata <= ctrl_word;
                `ADDR_ERROR:  o_rdata <= err_word;
                `ADDR_STATUS: o_rdata <= status_word;
                `ADDR_COUNTS: o_rdata <= counts_word;
                default:      o_rdata <= 32'h00000000;
            endcase
        end else begin
            o_rdata <= 32'h00000000;
        end
    end

endmodule

// file: meter_error_queue_trigger_ctl_test.sv
// bench for the error queue and trigger controller
`timescale 1ns/10ps
`include "meter_err_map.vh"
module meter_error_queue_trigger_ctl_test;
    logic        i_clk = 0, i_rst_n = 0, i_wr = 0, i_rd = 0, go = 0;
    logic        loc = 0, mem = 0, pend = 0, nv = 0, rs = 0, ext = 0, ovf = 0, inf = 0;
    logic [3:0]  op = 0, i_addr = 0;
    logic [15:0] nexp = 0;
    logic [8:0]  ndig = 0;
    logic [31:0] i_wdata = 0;
    logic [9:0]  cmd;
    wire  [31:0] o_rdata;
    wire  [1:0]  o_trig_state;
    wire         o_err_ind, o_beep, o_meas_start, o_math_on;
    int          bad_count = 0, n_compared = 0, cyc = 0, beeps = 0, i;
    bus_ctl_model ctl (.i_clk, .i_op(op), .i_go(go), .o_cmd(cmd));
    meter_error_queue_trigger_ctl dut (.i_clk, .i_rst_n, .i_cmd_init(cmd[0]),
        .i_cmd_read(cmd[1]), .i_cmd_meas(cmd[2]), .i_cmd_fetch(cmd[3]), .i_cmd_trg(cmd[4]),
        .i_cmd_cls(cmd[5]), .i_cmd_rst(cmd[6]), .i_dev_clear(cmd[7]), .i_cmd_data(cmd[8]),
        .i_talk_addr(cmd[9]), .i_out_overflow(ovf), .i_in_full(inf), .i_out_pending(pend),
        .i_num_valid(nv), .i_num_exp(nexp), .i_num_digits(ndig), .i_num_digits_ovf(1'b0),
        .i_mem_empty(mem), .i_ref_store(rs), .i_ref_overload(rs), .i_local(loc),
        .i_meas_done(1'b0), .i_ext_trig(ext), .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
        .o_err_ind, .o_beep, .o_meas_start, .o_math_on, .o_trig_state);
    // clock, beep count and hang guard
    always #12.5 i_clk = ~i_clk;
    always @(posedge i_clk) if (o_beep === 1'b1) beeps <= beeps + 1;
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            bad_count++;
            give_verdict;
        end
    end
    function automatic [31:0] sx(input [10:0] v);
        return {{21{v[10]}}, v};
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (e !== g) begin
            bad_count++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic c(input logic [3:0] k);
        op <= k;
        go <= 1;
        @(posedge i_clk) go <= 0;
        repeat (2) @(posedge i_clk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        i_addr <= a;
        i_wdata <= v;
        i_wr <= 1;
        @(posedge i_clk) i_wr <= 0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e, input string nm);
        i_addr <= a;
        i_rd <= 1;
        @(posedge i_clk) i_rd <= 0;
        @(posedge i_clk) chk(nm, e, o_rdata);
    endtask
    task automatic num(input logic [15:0] e, input logic [8:0] g);
        nexp <= e;
        ndig <= g;
        nv <= 1;
        @(posedge i_clk) nv <= 0;
        @(posedge i_clk);
    endtask
    task automatic st(input logic [1:0] e);
        chk("state", e, o_trig_state);
    endtask
    task automatic give_verdict;
        $display("compares %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // error sources, queue order, overflow and clearing
    initial begin
        repeat (20) @(posedge i_clk);
        i_rst_n <= 1;
        @(posedge i_clk);
        rd(`ADDR_ERROR, 0, "empty");
        rd(4'h7, 0, "unmapped");
        c(9);
        num(16'h7d01, 9'h0ff);
        num(16'h7d00, 9'h100);
        num(16'h7d00, 9'h0ff);
        loc <= 1;
        c(1);
        st(`ST_IDLE);
        loc <= 0;
        rd(`ADDR_ERROR, sx(`CODE_QUERY_UNT), "fifo0");
        chk("beeps", 4, beeps);
        rd(`ADDR_ERROR, sx(`CODE_NUM_OVF), "fifo1");
        rd(`ADDR_ERROR, sx(`CODE_DIGITS), "fifo2");
        rd(`ADDR_ERROR, sx(`CODE_LOCAL), "fifo3");
        chk("ind", 0, o_err_ind);
        $display("test sources done");
        for (i = 0; i < 22; i++) num(16'h7d01, 0);
        chk("ind", 1, o_err_ind);
        c(6);
        rd(`ADDR_STATUS, 32'h94, "status");
        for (i = 0; i < 19; i++) rd(`ADDR_ERROR, sx(`CODE_NUM_OVF), "kept");
        rd(`ADDR_ERROR, sx(`CODE_TOO_MANY), "newest");
        rd(`ADDR_ERROR, 0, "drained");
        num(16'h7d01, 0);
        c(5);
        rd(`ADDR_ERROR, 0, "cleared");
        $display("test overflow done");
        wr(`ADDR_CTRL, `SRC_BUS);
        c(4);
        c(0);
        st(`ST_WAIT);
        c(4);
        st(`ST_MEAS);
        c(0);
        c(7);
        st(`ST_IDLE);
        c(1);
        c(7);
        wr(`ADDR_CTRL, `SRC_EXT);
        c(2);
        st(`ST_WAIT);
        ext <= 1;
        repeat (5) @(posedge i_clk);
        st(`ST_MEAS);
        c(7);
        mem <= 1;
        c(3);
        wr(`ADDR_COUNTS, 32'h0011_0020);
        c(0);
        st(`ST_IDLE);
        wr(`ADDR_CTRL, 32'h4);
        rd(`ADDR_CTRL, 32'h4, "math_set");
        rs <= 1;
        @(posedge i_clk) rs <= 0;
        repeat (2) @(posedge i_clk);
        chk("math", 0, o_math_on);
        pend <= 1;
        c(8);
        pend <= 0;
        ovf <= 1;
        inf <= 1;
        @(posedge i_clk) ovf <= 0;
        inf <= 0;
        @(posedge i_clk);
        rd(`ADDR_ERROR, sx(`CODE_TRIG_IGN), "trg_idle");
        rd(`ADDR_ERROR, sx(`CODE_INIT_IGN), "init_busy");
        rd(`ADDR_ERROR, sx(`CODE_TRIG_DEAD), "deadlock");
        rd(`ADDR_ERROR, sx(`CODE_DATA_STALE), "stale");
        rd(`ADDR_ERROR, sx(`CODE_NO_MEM), "mem_limit");
        rd(`ADDR_ERROR, sx(`CODE_OVL_REF), "ovl_ref");
        rd(`ADDR_ERROR, sx(`CODE_QUERY_INT), "interrupted");
        rd(`ADDR_ERROR, sx(`CODE_QUERY_DEAD), "out_dead");
        $display("test trigger done");
        give_verdict;
    end
endmodule
bind meter_error_queue_trigger_ctl qmon mon (.*);
